// [common/trms_pkg.sv]
// Purpose: Shared constants and types for the rail monitor sequencer.
// Assumes: 16-bit register bus with byte offsets, 20 MHz core clock.
// Notes:   Offsets, field positions, reset values and timing are named once here.
`default_nettype none
package trms_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CFG     = 8'h00;
   localparam logic [7:0] OFS_SHUNT1  = 8'h04;
   localparam logic [7:0] OFS_BUS1    = 8'h08;
   localparam logic [7:0] OFS_CH_STEP = 8'h08;
   localparam logic [7:0] OFS_CRIT1   = 8'h1c;
   localparam logic [7:0] OFS_SUM     = 8'h28;
   localparam logic [7:0] OFS_SUM_LIM = 8'h2c;
   localparam logic [7:0] OFS_MASK    = 8'h30;
   // Field positions.
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_EN_LSB   = 12;
   localparam int MASK_CONV_READY_FLAG    = 0;
   localparam int MASK_SF      = 6;
   localparam int MASK_CF_LSB  = 7;
   localparam int MASK_SCC_LSB = 12;
   // Reset values.
   localparam logic [15:0] CFG_RESET     = 16'h7007;
   localparam logic [12:0] CRIT_RESET    = 13'h0fff;
   localparam logic [14:0] SUM_LIM_RESET = 15'h3fff;
   localparam logic [2:0]  SCC_RESET     = 3'h0;
   // Timing: recovery is a least time, the bus timeout a longest one.
   localparam int RECOVERY_US  = 40;
   localparam int TIMEOUT_MS   = 28;
   localparam int CLK_KHZ      = 20000;
   localparam int RECOVERY_CYC = (RECOVERY_US * CLK_KHZ + 999) / 1000;
   localparam int TIMEOUT_CYC  = TIMEOUT_MS * CLK_KHZ;
   // Step index value meaning no further step.
   localparam logic [2:0] STEP_NONE = 3'h7;
   // One conversion request: channel and quantity.
   typedef struct packed {
      logic [1:0] chan;
      logic       is_bus;
   } trms_conv_t;
   // Sequencer states.
   typedef enum logic [1:0] {
      ST_DOWN    = 2'b00,
      ST_RECOVER = 2'b01,
      ST_LAUNCH  = 2'b10,
      ST_WAIT    = 2'b11
   } trms_state_t;
endpackage : trms_pkg
`default_nettype wire

// [hw/trms_top.sv]
// Purpose: Conversion sequencer, critical alert and register file.
// Assumes: Converter answers on the core clock; scl is asynchronous.
// Notes:   Bus results are 13-bit codes of 8 mV each, kept unscaled.
`timescale 1ns/1ns
`default_nettype none
module trms_top
   import trms_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYC   // Scl-low cycles before reset.
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output var  logic [15:0] rd_data,
   output var  logic        conv_start,
   output var  trms_conv_t  conv_req,
   input  wire logic        conv_done,
   input  wire logic [12:0] conv_data,
   input  wire logic        scl_in,
   output var  logic        serial_reset,
   output var  logic [3:0]  alert_out,
   output var  logic [3:0]  alert_oe
);
   // The timeout counter must hold the count and at least one cycle.
   if (TIMEOUT < 1 || TIMEOUT > 1048575) begin : g_bad_timeout
      $error("TIMEOUT out of range");
   end

   localparam logic [9:0]  REC_LOAD = 10'(RECOVERY_CYC - 1);
   localparam logic [19:0] TO_LAST  = 20'(TIMEOUT - 1);

   trms_state_t        state, next_state;           // Sequencer state.
   logic [2:0]         step, next_step;             // Current step index.
   logic [9:0]         rec_cnt, next_rec_cnt;       // Recovery countdown.
   logic [15:0]        cfg, next_cfg;               // Configuration.
   logic [12:0]        shunt [3], next_shunt [3];   // Shunt results.
   logic [12:0]        bus_v [3], next_bus_v [3];   // Bus results, 8 mV.
   logic [12:0]        crit_lim [3], next_crit_lim [3];
   logic [14:0]        sum, next_sum;               // Shunt sum.
   logic [14:0]        sum_lim, next_sum_lim;       // Sum limit.
   logic [2:0]         sum_channel_select, next_scc;
   logic [2:0]         crit_channel_flags, next_cf;
   logic               sum_alert_flag, next_sf;
   logic               conv_ready_flag, next_conv_ready_flag;
   logic [15:0]        next_rd_data;
   logic               next_conv_start;
   trms_conv_t         next_conv_req;
   logic               pass_end;                    // Pass finishes now.
   logic               cfg_wr, mask_rd;             // Decoded accesses.
   logic               scl_meta, scl_sync;          // Scl synchroniser.
   logic [19:0]        low_cnt, next_low_cnt;       // Scl-low time.
   logic               next_serial_reset;

   // Finds the first step at or after start that is enabled and measured.
   function automatic logic [2:0] first_step(input logic [2:0] start,
                                             input logic [15:0] c);
      logic [2:0] res;
      res = STEP_NONE;
      for (int i = 5; i >= 0; i--) begin
         if (3'(i) >= start && c[CFG_EN_LSB + i / 2] &&
             c[CFG_MODE_LSB + i % 2]) begin
            res = 3'(i);
         end
      end
      return res;
   endfunction : first_step

   // Sign-extends a 13-bit shunt code to the sum width.
   function automatic logic [14:0] sext(input logic [12:0] v);
      return {{2{v[12]}}, v};
   endfunction : sext

   // A mode with neither quantity selected is power-down.
   function automatic logic is_active(input logic [2:0] m);
      return m[1:0] != 2'b00;
   endfunction : is_active

   assign cfg_wr  = wr_stb && addr == OFS_CFG;
   assign mask_rd = rd_stb && addr == OFS_MASK;

   // Next-value logic for registers, sequencer and flags. Clears are
   // applied before sets so that a hardware event never gets lost.
   always_comb begin
      logic [2:0] nxt;
      logic [1:0] ch;
      nxt = STEP_NONE;
      ch = step[2:1];
      next_state = state;
      next_step = step;
      next_rec_cnt = rec_cnt;
      next_cfg = cfg;
      next_shunt = shunt;
      next_bus_v = bus_v;
      next_crit_lim = crit_lim;
      next_sum = sum;
      next_sum_lim = sum_lim;
      next_scc = sum_channel_select;
      next_cf = crit_channel_flags;
      next_sf = sum_alert_flag;
      next_conv_ready_flag = conv_ready_flag;
      next_conv_start = 1'b0;
      next_conv_req = conv_req;
      pass_end = 1'b0;

      // Software writes; limits apply from the next comparison on.
      if (wr_stb) begin
         if (addr == OFS_CFG) begin
            next_cfg = wr_data;
            if (is_active(wr_data[2:0])) begin
               next_conv_ready_flag = 1'b0;
            end
         end else if (addr == OFS_MASK) begin
            next_scc = wr_data[MASK_SCC_LSB +: 3];
         end else if (addr == OFS_SUM_LIM) begin
            next_sum_lim = wr_data[14:0];
         end else begin
            for (int i = 0; i < 3; i++) begin
               if (addr == OFS_CRIT1 + 8'(4 * i)) begin
                  next_crit_lim[i] = wr_data[12:0];
               end
            end
         end
      end

      if (mask_rd) begin
         next_conv_ready_flag = 1'b0;
         next_cf = 3'h0;
         next_sf = 1'b0;
      end

      // Sequencer.
      case (state)
         ST_DOWN: begin
            next_state = ST_DOWN;
         end
         ST_RECOVER: begin
            if (rec_cnt != 10'h000) begin
               next_rec_cnt = rec_cnt - 10'h001;
            end else begin
               nxt = first_step(3'h0, cfg);
               if (nxt == STEP_NONE) begin
                  pass_end = 1'b1;
               end else begin
                  next_step = nxt;
                  next_state = ST_LAUNCH;
               end
            end
         end
         ST_LAUNCH: begin
            next_conv_start = 1'b1;
            next_conv_req.chan = step[2:1];
            next_conv_req.is_bus = step[0];
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (conv_done) begin
               if (step[0]) begin
                  next_bus_v[ch] = conv_data;
               end else begin
                  next_shunt[ch] = conv_data;
                  if ($signed(conv_data) > $signed(crit_lim[ch])) begin
                     next_cf[ch] = 1'b1;
                  end
               end
               nxt = first_step(step + 3'h1, cfg);
               if (nxt == STEP_NONE) begin
                  pass_end = 1'b1;
               end else begin
                  next_step = nxt;
                  next_state = ST_LAUNCH;
               end
            end
         end
         default: begin
            next_state = ST_DOWN;
         end
      endcase

      if (pass_end) begin
         next_conv_ready_flag = 1'b1;
         if (sum_channel_select != 3'h0) begin
            next_sum = 15'h0000;
            for (int i = 0; i < 3; i++) begin
               if (sum_channel_select[i]) begin
                  next_sum = next_sum + sext(next_shunt[i]);
               end
            end
            if ($signed(next_sum) > $signed(sum_lim)) begin
               next_sf = 1'b1;
            end
         end
         nxt = first_step(3'h0, cfg);
         if (cfg[CFG_MODE_LSB + 2] && nxt != STEP_NONE) begin
            next_step = nxt;
            next_state = ST_LAUNCH;
         end else begin
            next_state = ST_DOWN;
         end
      end

      // A config write overrides the sequencer: power-down stops at once,
      // any active mode restarts a fresh pass.
      if (cfg_wr) begin
         // A start launched now would run under the old mode, so drop it.
         next_conv_start = 1'b0;
         next_conv_req = conv_req;
         if (!is_active(wr_data[2:0])) begin
            next_state = ST_DOWN;
         end else begin
            next_state = ST_RECOVER;
            next_rec_cnt = (state == ST_DOWN) ? REC_LOAD : 10'h000;
         end
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_comb begin
      next_rd_data = 16'h0000;
      if (rd_stb) begin
         if (addr == OFS_CFG) begin
            next_rd_data = cfg;
         end else if (addr == OFS_SUM) begin
            next_rd_data = {sum[14], sum};
         end else if (addr == OFS_SUM_LIM) begin
            next_rd_data = {sum_lim[14], sum_lim};
         end else if (addr == OFS_MASK) begin
            next_rd_data[MASK_SCC_LSB +: 3] = sum_channel_select;
            next_rd_data[MASK_CF_LSB +: 3] = crit_channel_flags;
            next_rd_data[MASK_SF] = sum_alert_flag;
            next_rd_data[MASK_CONV_READY_FLAG] = conv_ready_flag;
         end else begin
            for (int i = 0; i < 3; i++) begin
               if (addr == OFS_SHUNT1 + 8'(i) * OFS_CH_STEP) begin
                  next_rd_data = {{3{shunt[i][12]}}, shunt[i]};
               end
               if (addr == OFS_BUS1 + 8'(i) * OFS_CH_STEP) begin
                  next_rd_data = {3'h0, bus_v[i]};
               end
               if (addr == OFS_CRIT1 + 8'(4 * i)) begin
                  next_rd_data = {{3{crit_lim[i][12]}}, crit_lim[i]};
               end
            end
         end
      end
   end

   // Serial timeout counts synchronised scl-low cycles and saturates,
   // so one long low gives one reset pulse.
   always_comb begin
      next_low_cnt = low_cnt;
      next_serial_reset = 1'b0;
      if (scl_sync) begin
         next_low_cnt = 20'h00000;
      end else if (low_cnt != TO_LAST + 20'h00001) begin
         next_low_cnt = low_cnt + 20'h00001;
         if (low_cnt == TO_LAST) begin
            next_serial_reset = 1'b1;
         end
      end
   end

   // Registers only. The sequencer starts in recovery because the reset
   // configuration is continuous conversion.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_RECOVER;
         step <= 3'h0;
         rec_cnt <= REC_LOAD;
         cfg <= CFG_RESET;
         crit_lim <= '{CRIT_RESET, CRIT_RESET, CRIT_RESET};
         shunt <= '{13'h0000, 13'h0000, 13'h0000};
         bus_v <= '{13'h0000, 13'h0000, 13'h0000};
         sum <= 15'h0000;
         sum_lim <= SUM_LIM_RESET;
         sum_channel_select <= SCC_RESET;
         crit_channel_flags <= 3'h0;
         sum_alert_flag <= 1'b0;
         conv_ready_flag <= 1'b0;
         rd_data <= 16'h0000;
         conv_start <= 1'b0;
         conv_req <= '0;
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         low_cnt <= 20'h00000;
         serial_reset <= 1'b0;
         alert_out <= 4'h0;
         alert_oe <= 4'h0;
      end else begin
         state <= next_state;
         step <= next_step;
         rec_cnt <= next_rec_cnt;
         cfg <= next_cfg;
         crit_lim <= next_crit_lim;
         shunt <= next_shunt;
         bus_v <= next_bus_v;
         sum <= next_sum;
         sum_lim <= next_sum_lim;
         sum_channel_select <= next_scc;
         crit_channel_flags <= next_cf;
         sum_alert_flag <= next_sf;
         conv_ready_flag <= next_conv_ready_flag;
         rd_data <= next_rd_data;
         conv_start <= next_conv_start;
         conv_req <= next_conv_req;
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         low_cnt <= next_low_cnt;
         serial_reset <= next_serial_reset;
         alert_out <= 4'h0;
         alert_oe <= {3'h0, (|next_cf) | next_sf};
      end
   end

   // Checks.
   property p_skip;
      @(posedge core_clk) disable iff (!rst_b)
      conv_start |-> cfg[CFG_EN_LSB + conv_req.chan];
   endproperty
   a_skip: assert property (p_skip) else $error("disabled channel");

   property p_quantity;
      @(posedge core_clk) disable iff (!rst_b)
      conv_start |-> cfg[CFG_MODE_LSB + conv_req.is_bus];
   endproperty
   a_quantity: assert property (p_quantity) else $error("bad quantity");

   logic [1:0] ch_q;  // Channel of the current step, for past-value checks.
   assign ch_q = step[2:1];
   // A config write in the launch cycle withholds the start, hence its exclusion.
   property p_shunt_then_bus;
      @(posedge core_clk) disable iff (!rst_b)
      state == ST_WAIT && conv_done && !step[0] && cfg[1] && !wr_stb ##1 !cfg_wr
      |=> conv_start && conv_req.is_bus && conv_req.chan == $past(ch_q, 2);
   endproperty
   a_shunt_then_bus: assert property (p_shunt_then_bus) else $error("order");

   property p_down_holds;
      @(posedge core_clk) disable iff (!rst_b)
      state == ST_DOWN && !cfg_wr |=> state == ST_DOWN && !conv_start;
   endproperty
   a_down_holds: assert property (p_down_holds) else $error("left down");

   property p_wake;
      @(posedge core_clk) disable iff (!rst_b)
      state == ST_DOWN && cfg_wr && is_active(wr_data[2:0])
      |=> state == ST_RECOVER && rec_cnt == REC_LOAD;
   endproperty
   a_wake: assert property (p_wake) else $error("no recovery");

   property p_ready_set;
      @(posedge core_clk) disable iff (!rst_b)
      pass_end |=> conv_ready_flag;
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("ready not set");

   property p_ready_clear;
      @(posedge core_clk) disable iff (!rst_b)
      (mask_rd || (cfg_wr && is_active(wr_data[2:0]))) && !pass_end
      |=> !conv_ready_flag;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready kept");

   property p_crit;
      @(posedge core_clk) disable iff (!rst_b)
      state == ST_WAIT && conv_done && !step[0] &&
      $signed(conv_data) > $signed(crit_lim[step[2:1]])
      |=> crit_channel_flags[$past(ch_q)] && alert_oe[0] && !alert_out[0];
   endproperty
   a_crit: assert property (p_crit) else $error("critical missed");

   property p_single;
      @(posedge core_clk) disable iff (!rst_b)
      pass_end && !cfg[2] && !cfg_wr |=> state == ST_DOWN;
   endproperty
   a_single: assert property (p_single) else $error("not down");

   c_cont: cover property (@(posedge core_clk) disable iff (!rst_b)
      pass_end && cfg[2] ##1 state == ST_LAUNCH);
   c_sum: cover property (@(posedge core_clk) disable iff (!rst_b)
      $rose(sum_alert_flag));
   c_timeout: cover property (@(posedge core_clk) disable iff (!rst_b)
      serial_reset);
endmodule : trms_top
`default_nettype wire

// [verif/trms_conv_model.sv]
// Purpose: Behavioural converter that answers the sequencer's requests.
// Assumes: One conv_start per conversion, on the core clock.
// Notes:   The data lines toggle between answers, so a stale value never matches.
`timescale 1ns/1ns
`default_nettype none
module trms_conv_model
   import trms_pkg::*;
#(
   parameter logic [12:0] SHUNT = 13'h1ff0,  // Channel 0 shunt code; others add chan.
   parameter logic [12:0] BUS   = 13'h0fa0   // Channel 0 bus code; others add chan.
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        conv_start,
   input  wire trms_conv_t  conv_req,
   input  wire logic        slow,
   output var  logic        conv_done,
   output var  logic [12:0] conv_data
);
   logic [3:0] cnt;  // Cycles left in the running conversion.
   trms_conv_t req;  // Request being converted.
   // Counts the conversion time down and answers exactly once.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 4'h0;
         req <= '0;
         conv_done <= 1'b0;
         conv_data <= 13'h0000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start) begin
            cnt <= slow ? 4'hc : 4'h3;
            req <= conv_req;
         end else if (cnt == 4'h1) begin
            cnt <= 4'h0;
            conv_done <= 1'b1;
            conv_data <= (req.is_bus ? BUS : SHUNT) + 13'(req.chan);
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : trms_conv_model
`default_nettype wire

// [verif/trms_top_tb_top.sv]
// Purpose: Self-checking bench for the rail monitor sequencer.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes:   The scl timeout is shortened to 20 cycles to keep the run short.
`timescale 1ns/1ns
`default_nettype none
module trms_top_tb_top
   import trms_pkg::*;
;
   localparam int TMO = 20;  // Shortened scl timeout.
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic        scl_in = 1'b1;
   logic        slow = 1'b0;
   logic [15:0] rd_data;
   logic        conv_start;
   trms_conv_t  conv_req;
   logic        conv_done;
   logic [12:0] conv_data;
   logic        serial_reset;
   logic [3:0]  alert_out;
   logic [3:0]  alert_oe;
   int          mismatches = 0;
   int          comparisons = 0;
   int          n;
   logic [15:0] d;
   logic [2:0]  seq[$];  // Launched steps as {chan, is_bus}.
   logic [15:0] cfgs[4] = '{16'h7007, 16'h5007, 16'h7005, 16'h7006};
   logic [27:0] exps[4] = '{28'h0123450, 28'h0145014, 28'h0240240, 28'h1351351};
   // Free-running 20 MHz clock.
   always #25 core_clk = ~core_clk;
   trms_top #(.TIMEOUT(TMO)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done),
      .conv_data(conv_data), .scl_in(scl_in), .serial_reset(serial_reset),
      .alert_out(alert_out), .alert_oe(alert_oe));
   trms_conv_model conv_u (.core_clk(core_clk), .rst_b(rst_b), .conv_start(conv_start),
      .conv_req(conv_req), .slow(slow), .conv_done(conv_done), .conv_data(conv_data));
   // Records every launched conversion; conv_req is held with the start pulse.
   always @(posedge core_clk) begin
      if (conv_start === 1'b1) seq.push_back({conv_req.chan, conv_req.is_bus});
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk);
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 v = rd_data;
   endtask : rd
   // Waits, bounded, for k launched steps, then lets the pass settle.
   task automatic wait_steps(input int k);
      int t;
      for (t = 0; t < 3000 && seq.size() < k; t++) @(posedge core_clk);
      if (seq.size() < k) begin
         mismatches++;
         give_verdict();
      end
      repeat (20) @(posedge core_clk);
   endtask : wait_steps
   // Power-down write, so that no conversion is in flight when the log restarts.
   task automatic quiet(input logic [15:0] en);
      wr(OFS_CFG, en);
      repeat (30) @(posedge core_clk);
      seq.delete();
   endtask : quiet
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(OFS_CRIT1 + 8'(4 * i), d);
         check("crit_limit", d, 16'h0fff);
      end
      rd(OFS_CFG, d);
      check("cfg", d, CFG_RESET);
      rd(8'h3e, d);
      check("unmapped", d, 16'h0000);
      @(posedge core_clk);
      #1 check("rd_idle", rd_data, 16'h0000);
      // Continuous passes: all, skip middle, shunt only (slow), bus only.
      for (int k = 0; k < 4; k++) begin
         slow <= (k == 2);
         quiet(16'h7000);
         wr(OFS_CFG, cfgs[k]);
         wait_steps(7);
         for (int i = 0; i < 7; i++) begin
            d = {12'h0, exps[k][27-4*i -: 4]};
            check("step", {13'h0, seq[i]}, d);
         end
      end
      quiet(16'h7000);
      for (int i = 0; i < 3; i++) begin
         rd(OFS_SHUNT1 + 8'(8 * i), d);
         check("shunt", d, 16'hfff0 + 16'(i));
         rd(OFS_BUS1 + 8'(8 * i), d);
         check("bus", d, 16'h0fa0 + 16'(i));
      end
      check("alert_idle", {8'h0, alert_out, alert_oe}, 16'h0000);
      // Single-shot modes on the middle channel only.
      for (int m = 1; m < 4; m++) begin
         wr(OFS_CFG, 16'h2000 | 16'(m));
         n = (m == 3) ? 2 : 1;
         wait_steps(n);
         check("shots", 16'(seq.size()), 16'(n));
         check("first", {13'h0, seq[0]}, (m == 2) ? 16'h0003 : 16'h0002);
         if (m == 3) check("second", {13'h0, seq[1]}, 16'h0003);
         quiet(16'h2000);
         rd(OFS_MASK, d);
         check("ready", {15'h0, d[MASK_CONV_READY_FLAG]}, 16'h0001);
         rd(OFS_MASK, d);
         check("ready_clr", {15'h0, d[MASK_CONV_READY_FLAG]}, 16'h0000);
      end
      // Same value written twice: each write is a new trigger.
      wr(OFS_CFG, 16'h2003);
      wait_steps(2);
      wr(OFS_CFG, 16'h2003);
      rd(OFS_MASK, d);
      check("ready_wr_clr", {15'h0, d[MASK_CONV_READY_FLAG]}, 16'h0000);
      wait_steps(4);
      check("retrigger", 16'(seq.size()), 16'h0004);
      // Middle-channel limit below its reading of -15.
      wr(OFS_CRIT1 + 8'h04, 16'hffe0);
      seq.delete();
      wr(OFS_CFG, 16'h2001);
      repeat (RECOVERY_CYC - 10) @(posedge core_clk);
      check("recovery", 16'(seq.size()), 16'h0000);
      wait_steps(1);
      check("crit_pin", {8'h0, alert_out, alert_oe}, 16'h0001);
      rd(OFS_MASK, d);
      check("crit_mask", d & 16'h03c1, 16'h0101);
      repeat (3) @(posedge core_clk);
      check("crit_rel", {8'h0, alert_out, alert_oe}, 16'h0000);
      // Sum of three shunts (-45) against a limit of -64.
      wr(OFS_CRIT1 + 8'h04, 16'h0fff);
      wr(OFS_MASK, 16'h7000);
      wr(OFS_SUM_LIM, 16'hffc0);
      seq.delete();
      wr(OFS_CFG, 16'h7001);
      wait_steps(3);
      wr(OFS_SUM, 16'h1234);
      rd(OFS_SUM, d);
      check("sum", d, 16'hffd3);
      check("sum_pin", {8'h0, alert_out, alert_oe}, 16'h0001);
      rd(OFS_MASK, d);
      check("sum_mask", d & 16'h73c1, 16'h7041);
      // Scl held low until the serial side resets.
      @(posedge core_clk);
      scl_in <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (serial_reset !== 1'b1 && n < 100);
      check("timeout", 16'(n >= TMO && n <= TMO + 8), 16'h0001);
      @(posedge core_clk);
      #1 check("tmo_pulse", {15'h0, serial_reset}, 16'h0000);
      @(posedge core_clk);
      scl_in <= 1'b1;
      give_verdict();
   end
endmodule : trms_top_tb_top
`default_nettype wire
